//--- rtl/runaway_counter.sv
// Purpose: Phase divider, binary counter and tap overflow detect of the runaway timer.
// Assumes: Clear and hold come from logic on the same clock.
// Notes: Tap i wraps after 2^(TAP_BASE+2i) phase ticks, that is 2^(16+2i) clocks.
`timescale 1ns/1ps
`include "runaway_timer_defs.svh"
module runaway_counter #(
	parameter int CNT_W = `RUNAWAY_CNT_W,
	parameter int TAP_BASE = `RUNAWAY_TAP_BASE
) (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Control.
	input wire logic clear_in,
	input wire logic hold_in,
	input wire logic [1:0] period_sel_in,
	// Results.
	output logic [CNT_W-1:0] count_out,
	output logic tap_ovf_out
);
	logic phase_q;
	logic [CNT_W-1:0] count_q;
	logic [`RUNAWAY_TAP_NUM-1:0] tap_full;

	// The phase clock runs at half the system clock.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase_q <= 1'b0;
		end else if (hold_in) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count_q <= '0;
		end else if (hold_in || clear_in) begin
			count_q <= '0;
		end else if (phase_q) begin
			count_q <= count_q + 1'b1;
		end
	end

	for (genvar i = 0; i < `RUNAWAY_TAP_NUM; i++) begin : g_tap
		assign tap_full[i] = &count_q[TAP_BASE+2*i-1:0];
	end

	assign tap_ovf_out = phase_q && tap_full[period_sel_in] && !hold_in && !clear_in;
	assign count_out = count_q;

	property p_cnt_hold;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(hold_in || clear_in) |=> (count_q == '0);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("counter not zeroed by clear or standby");

	property p_cnt_step;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(!hold_in && !clear_in)[*3] |-> (count_q == $past(count_q, 2) + 1'b1);
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter failed to advance at the phase rate");
endmodule

//--- rtl/runaway_detect_timer.sv
// Purpose: Runaway detection watchdog with an AXI4-Lite register slave.
// Assumes: standby_in is a level from the CPU on this clock; the bus release pin is asynchronous.
// Notes: One write and one read are handled at a time; only byte lane 0 writes the registers.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "runaway_timer_defs.svh"
module runaway_detect_timer #(
	parameter int TAP_BASE = `RUNAWAY_TAP_BASE
) (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// AXI4-Lite write address.
	input wire logic [`RUNAWAY_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	// AXI4-Lite write data.
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read address.
	input wire logic [`RUNAWAY_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	// AXI4-Lite read data.
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// CPU state.
	input wire logic standby_in,
	input wire logic bus_release_ack_n_in,
	// Runaway outputs.
	output logic runaway_out_n_out,
	output logic chip_reset_n_out,
	output logic runaway_irq_out
);
	logic aw_take;
	logic w_take;
	logic wr_do;
	logic aw_hold_q;
	logic aw_hold_d;
	logic w_hold_q;
	logic w_hold_d;
	logic bvalid_d;
	logic [`RUNAWAY_ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic ar_take;
	logic rvalid_d;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic byte_wr;
	logic mode_wr;
	logic cmd_wr;
	logic status_wr;
	logic mask_wr;
	logic cmd_clear;
	logic cmd_disable;
	logic enable_q;
	logic disabled_q;
	logic link_q;
	logic [1:0] period_q;
	logic [`RUNAWAY_STAT_W-1:0] status_q;
	logic [`RUNAWAY_STAT_W-1:0] mask_q;
	logic [`RUNAWAY_STAT_W-1:0] status_set;
	logic busrel_s1_q;
	logic busrel_s2_q;
	logic [`RUNAWAY_CNT_W-1:0] count;
	logic tap_ovf;
	logic guard_ovf;
	runaway_timer_pkg::out_state_type out_state_q;
	logic [`RUNAWAY_PULSE_CNT_W-1:0] pulse_cnt_q;
	logic out_n_q;
	logic chip_rst_n_q;
	logic irq_q;
	logic [31:0] rd_mux;
	logic [1:0] rd_resp;

	// Write channel: address and data are taken independently, the response follows both.
	assign aw_take = s_axi_awvalid_in && awready_q;
	assign w_take = s_axi_wvalid_in && wready_q;
	assign wr_do = aw_hold_q && w_hold_q;
	assign aw_hold_d = (aw_hold_q || aw_take) && !wr_do;
	assign w_hold_d = (w_hold_q || w_take) && !wr_do;
	assign bvalid_d = wr_do || (bvalid_q && !s_axi_bready_in);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready_q <= !aw_hold_d && !bvalid_d;
			wready_q <= !w_hold_d && !bvalid_d;
			bvalid_q <= bvalid_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bresp_q <= `RUNAWAY_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr_q <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_data_q <= s_axi_wdata_in;
				w_strb_q <= s_axi_wstrb_in;
			end
			if (wr_do) begin
				if (aw_addr_q == `RUNAWAY_ADDR_MODE || aw_addr_q == `RUNAWAY_ADDR_CMD ||
					aw_addr_q == `RUNAWAY_ADDR_STATUS || aw_addr_q == `RUNAWAY_ADDR_MASK ||
					aw_addr_q == `RUNAWAY_ADDR_COUNT) begin
					bresp_q <= `RUNAWAY_RESP_OKAY;
				end else begin
					bresp_q <= `RUNAWAY_RESP_SLVERR;
				end
			end
		end
	end

	// Register write strobes; only byte lane 0 carries register bits.
	assign byte_wr = wr_do && w_strb_q[0];
	assign mode_wr = byte_wr && (aw_addr_q == `RUNAWAY_ADDR_MODE);
	assign cmd_wr = byte_wr && (aw_addr_q == `RUNAWAY_ADDR_CMD);
	assign status_wr = byte_wr && (aw_addr_q == `RUNAWAY_ADDR_STATUS);
	assign mask_wr = byte_wr && (aw_addr_q == `RUNAWAY_ADDR_MASK);
	assign cmd_clear = cmd_wr && (w_data_q[7:0] == `RUNAWAY_CODE_CLEAR);
	assign cmd_disable = cmd_wr && (w_data_q[7:0] == `RUNAWAY_CODE_DISABLE);

	// Mode register fields.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			enable_q <= 1'b1;
			period_q <= `RUNAWAY_PERIOD_RESET;
			link_q <= 1'b0;
		end else if (mode_wr) begin
			enable_q <= w_data_q[`RUNAWAY_MODE_ENABLE_BIT];
			period_q <= w_data_q[`RUNAWAY_MODE_PERIOD_MSB:`RUNAWAY_MODE_PERIOD_LSB];
			link_q <= w_data_q[`RUNAWAY_MODE_LINK_BIT];
		end
	end

	// The guard only turns off when the disable code lands after the enable bit was cleared.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			disabled_q <= 1'b0;
		end else if (mode_wr && w_data_q[`RUNAWAY_MODE_ENABLE_BIT]) begin
			disabled_q <= 1'b0;
		end else if (cmd_disable && !enable_q) begin
			disabled_q <= 1'b1;
		end
	end

	// Bus release acknowledge is only observed; counting never depends on it.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			busrel_s1_q <= 1'b1;
			busrel_s2_q <= 1'b1;
		end else begin
			busrel_s1_q <= bus_release_ack_n_in;
			busrel_s2_q <= busrel_s1_q;
		end
	end

	runaway_counter #(
		.CNT_W(`RUNAWAY_CNT_W),
		.TAP_BASE(TAP_BASE)
	) u_counter (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.clear_in(cmd_clear),
		.hold_in(standby_in),
		.period_sel_in(period_q),
		.count_out(count),
		.tap_ovf_out(tap_ovf)
	);

	assign guard_ovf = tap_ovf && !disabled_q;

	// Output state: low until disabled and cleared, or a timed pulse when linked to reset.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			out_state_q <= runaway_timer_pkg::OUT_HIGH;
			pulse_cnt_q <= '0;
			out_n_q <= 1'b1;
			chip_rst_n_q <= 1'b1;
		end else begin
			case (out_state_q)
				runaway_timer_pkg::OUT_HIGH: begin
					if (guard_ovf && link_q) begin
						out_state_q <= runaway_timer_pkg::OUT_PULSE;
						pulse_cnt_q <= `RUNAWAY_PULSE_CNT_W'(`RUNAWAY_RST_PULSE_CYCLES - 1);
						out_n_q <= 1'b0;
						chip_rst_n_q <= 1'b0;
					end else if (guard_ovf) begin
						out_state_q <= runaway_timer_pkg::OUT_LOW;
						out_n_q <= 1'b0;
					end
				end
				runaway_timer_pkg::OUT_LOW: begin
					if (cmd_clear && disabled_q) begin
						out_state_q <= runaway_timer_pkg::OUT_HIGH;
						out_n_q <= 1'b1;
					end
				end
				runaway_timer_pkg::OUT_PULSE: begin
					if (pulse_cnt_q == '0) begin
						out_state_q <= runaway_timer_pkg::OUT_HIGH;
						out_n_q <= 1'b1;
						chip_rst_n_q <= 1'b1;
					end else begin
						pulse_cnt_q <= pulse_cnt_q - 1'b1;
					end
				end
				default: begin
					out_state_q <= runaway_timer_pkg::OUT_HIGH;
					out_n_q <= 1'b1;
					chip_rst_n_q <= 1'b1;
				end
			endcase
		end
	end

	// Sticky events; a new event wins over a write-one-to-clear in the same cycle.
	always_comb begin
		status_set = '0;
		status_set[`RUNAWAY_STAT_OVF_BIT] = guard_ovf;
		status_set[`RUNAWAY_STAT_RST_BIT] = guard_ovf && link_q && (out_state_q == runaway_timer_pkg::OUT_HIGH);
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_q <= '0;
		end else if (status_wr) begin
			status_q <= (status_q & ~w_data_q[`RUNAWAY_STAT_W-1:0]) | status_set;
		end else begin
			status_q <= status_q | status_set;
		end
	end

	// The mask resets open so the runaway interrupt behaves as non-maskable out of reset.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mask_q <= `RUNAWAY_MASK_RESET;
		end else if (mask_wr) begin
			mask_q <= w_data_q[`RUNAWAY_STAT_W-1:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

	// Read channel.
	always_comb begin
		rd_mux = '0;
		rd_resp = `RUNAWAY_RESP_OKAY;
		if (s_axi_araddr_in == `RUNAWAY_ADDR_MODE) begin
			rd_mux[`RUNAWAY_MODE_ENABLE_BIT] = enable_q;
			rd_mux[`RUNAWAY_MODE_PERIOD_MSB:`RUNAWAY_MODE_PERIOD_LSB] = period_q;
			rd_mux[`RUNAWAY_MODE_LINK_BIT] = link_q;
		end else if (s_axi_araddr_in == `RUNAWAY_ADDR_CMD) begin
			rd_mux = '0;
		end else if (s_axi_araddr_in == `RUNAWAY_ADDR_STATUS) begin
			rd_mux[`RUNAWAY_STAT_W-1:0] = status_q;
		end else if (s_axi_araddr_in == `RUNAWAY_ADDR_MASK) begin
			rd_mux[`RUNAWAY_STAT_W-1:0] = mask_q;
		end else if (s_axi_araddr_in == `RUNAWAY_ADDR_COUNT) begin
			rd_mux[`RUNAWAY_CNT_W-1:0] = count;
			rd_mux[`RUNAWAY_BUSREL_BIT] = busrel_s2_q;
		end else begin
			rd_resp = `RUNAWAY_RESP_SLVERR;
		end
	end

	assign ar_take = s_axi_arvalid_in && arready_q;
	assign rvalid_d = ar_take || (rvalid_q && !s_axi_rready_in);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `RUNAWAY_RESP_OKAY;
		end else begin
			arready_q <= !rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_mux;
				rresp_q <= rd_resp;
			end
		end
	end

	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rdata_out = rdata_q;
	assign s_axi_rresp_out = rresp_q;
	assign runaway_out_n_out = out_n_q;
	assign chip_reset_n_out = chip_rst_n_q;
	assign runaway_irq_out = irq_q;

	property p_ovf_drops_out;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(guard_ovf && out_state_q == runaway_timer_pkg::OUT_HIGH) |=> !runaway_out_n_out;
	endproperty
	a_ovf_drops_out: assert property (p_ovf_drops_out) else $error("overflow did not drive the output low");

	property p_out_held_low;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(out_state_q == runaway_timer_pkg::OUT_LOW && !(cmd_clear && disabled_q)) |=> !runaway_out_n_out;
	endproperty
	a_out_held_low: assert property (p_out_held_low) else $error("output released without disable and clear");

	property p_out_release;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(out_state_q == runaway_timer_pkg::OUT_LOW && cmd_clear && disabled_q) |=> runaway_out_n_out;
	endproperty
	a_out_release: assert property (p_out_release) else $error("output not released after disable and clear");

	property p_reset_pulse;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		$fell(chip_reset_n_out) |-> (!runaway_out_n_out && !chip_reset_n_out) ##15 !chip_reset_n_out ##1 chip_reset_n_out;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("linked reset pulse has wrong length");

	property p_no_pulse_unlinked;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(!link_q && out_state_q != runaway_timer_pkg::OUT_PULSE) |=> chip_reset_n_out;
	endproperty
	a_no_pulse_unlinked: assert property (p_no_pulse_unlinked) else $error("chip reset driven while unlinked");

	property p_disable_needs_clear_bit;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(cmd_disable && enable_q && !disabled_q) |=> !disabled_q;
	endproperty
	a_disable_needs_clear_bit: assert property (p_disable_needs_clear_bit) else $error("guard disabled with enable set");

	property p_reenable;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(mode_wr && w_data_q[`RUNAWAY_MODE_ENABLE_BIT]) |=> (!disabled_q && enable_q);
	endproperty
	a_reenable: assert property (p_reenable) else $error("enable bit write did not re-arm the guard");

	property p_disabled_silent;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(disabled_q && out_state_q == runaway_timer_pkg::OUT_HIGH) |=> runaway_out_n_out;
	endproperty
	a_disabled_silent: assert property (p_disabled_silent) else $error("disabled guard drove the output");

	property p_standby_zero;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		standby_in |=> (count == '0);
	endproperty
	a_standby_zero: assert property (p_standby_zero) else $error("counter not held at zero in standby");

	property p_irq_follows;
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(status_q[`RUNAWAY_STAT_OVF_BIT] && mask_q[`RUNAWAY_STAT_OVF_BIT]) |=> runaway_irq_out;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("unmasked overflow did not raise the interrupt");
endmodule

//--- rtl/runaway_timer_defs.svh
// Purpose: Constants of the runaway detection timer: map, fields, codes and timing.
// Assumes: One 100 MHz system clock standing for the oscillator, so one state is two clocks.
// Notes: Registers sit in the low byte of aligned 32-bit words; upper bits read as zero, except the count word (22-bit count, bus release flag in bit 31).
//
// Notes on behaviour
// - 22-stage counter advancing once per two clocks.
// - Two-bit field picks one of four taps.
// - Period field resets to shortest tap.
// - Tap overflow while guarded raises interrupt, output low.
// - Unlinked output stays low until disabled then cleared.
// - Reset link pulses chip reset 8 states.
// - Reset link bit resets to zero.
// - Disable needs enable cleared plus disable code.
// - Setting enable alone re-arms the guard.
// - Counter keeps counting while guard disabled.
// - Clear code zeroes the counter.
// - Counter zeroed by reset and standby entry.
// - Uncleared counter wraps to zero and continues.
// - Counter halts in standby, runs otherwise.
// - Counter keeps running during bus release.
// - Counting starts right after reset release.
`ifndef RUNAWAY_TIMER_DEFS_SVH
`define RUNAWAY_TIMER_DEFS_SVH

`define RUNAWAY_CNT_W 22
`define RUNAWAY_TAP_BASE 15
`define RUNAWAY_TAP_NUM 4

`define RUNAWAY_ADDR_W 5
`define RUNAWAY_ADDR_MODE 5'h00
`define RUNAWAY_ADDR_CMD 5'h04
`define RUNAWAY_ADDR_STATUS 5'h08
`define RUNAWAY_ADDR_MASK 5'h0C
`define RUNAWAY_ADDR_COUNT 5'h10

`define RUNAWAY_MODE_ENABLE_BIT 7
`define RUNAWAY_MODE_PERIOD_MSB 6
`define RUNAWAY_MODE_PERIOD_LSB 5
`define RUNAWAY_MODE_LINK_BIT 2
`define RUNAWAY_PERIOD_RESET 2'h0
`define RUNAWAY_CODE_CLEAR 8'h4E
`define RUNAWAY_CODE_DISABLE 8'hB1

`define RUNAWAY_STAT_W 2
`define RUNAWAY_STAT_OVF_BIT 0
`define RUNAWAY_STAT_RST_BIT 1
`define RUNAWAY_MASK_RESET 2'h3
`define RUNAWAY_BUSREL_BIT 31

`define RUNAWAY_RESP_OKAY 2'h0
`define RUNAWAY_RESP_SLVERR 2'h2

`define RUNAWAY_CLKS_PER_STATE 2
`define RUNAWAY_RST_PULSE_STATES 8
`define RUNAWAY_RST_PULSE_CYCLES (`RUNAWAY_RST_PULSE_STATES * `RUNAWAY_CLKS_PER_STATE)
`define RUNAWAY_PULSE_CNT_W 5

`endif

//--- rtl/runaway_timer_pkg.sv
// Purpose: Types shared by the runaway detection timer.
// Assumes: Constants come from the defs header.
// Notes: Only the output state machine needs a type.
package runaway_timer_pkg;
	typedef enum logic [1:0] {OUT_HIGH, OUT_LOW, OUT_PULSE} out_state_type;
endpackage

//--- verif/runaway_peripheral.sv
// Purpose: Peripheral and system-reset side of the runaway pins, measuring each low pulse.
// Assumes: Both pins are active low and are sampled on the system clock.
// Notes: A length latches when its pin returns high, so a level still low reads as the previous pulse.
`timescale 1ns/1ps
module runaway_peripheral (
	// Clock.
	input wire logic sys_clk_in,
	// Pins watched.
	input wire logic runaway_out_n_in,
	input wire logic chip_reset_n_in,
	// Measured low lengths in clocks.
	output int out_low_len_out,
	output int rst_low_len_out
);
	int out_run_q;
	int rst_run_q;

	// A peripheral reset input sees the whole low time of the runaway pin.
	always @(posedge sys_clk_in) begin
		if (runaway_out_n_in === 1'b0) begin
			out_run_q <= out_run_q + 1;
		end else if (out_run_q != 0) begin
			out_low_len_out <= out_run_q;
			out_run_q <= 0;
		end
	end

	always @(posedge sys_clk_in) begin
		if (chip_reset_n_in === 1'b0) begin
			rst_run_q <= rst_run_q + 1;
		end else if (rst_run_q != 0) begin
			rst_low_len_out <= rst_run_q;
			rst_run_q <= 0;
		end
	end
endmodule

//--- verif/tb_top.sv
// Purpose: Self-checking bench of the runaway detection timer through its register bus.
// Assumes: One 100 MHz clock; the tap base is shortened so two real overflows fit in about 9k clocks.
// Notes: Longer taps are too slow to run and are checked as register fields only.
`timescale 1ns/1ps
`include "runaway_timer_defs.svh"
module tb_top;
	// Each phase tick is two clocks, so the shortest tap wraps after 2^(TAP_BASE+1) clocks.
	localparam int TAP_BASE = 11;
	localparam int OVF_CLKS = 2 ** (TAP_BASE + 1);
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] awaddr = 5'h00;
	logic [4:0] araddr = 5'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic standby = 1'b0, busrel_n = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, out_n, crst_n, irq;
	logic [1:0] bresp, rresp, wr_resp, rd_resp;
	logic [31:0] rdata, rd_val;
	int failures = 0, checked = 0, cyc = 0, wr_cyc, rd_cyc, out_len, rst_len;

	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	runaway_detect_timer #(.TAP_BASE(TAP_BASE)) u_dut (.sys_clk_in(clk), .rstn_in(rstn),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.standby_in(standby), .bus_release_ack_n_in(busrel_n),
		.runaway_out_n_out(out_n), .chip_reset_n_out(crst_n), .runaway_irq_out(irq));

	runaway_peripheral u_peer (.sys_clk_in(clk), .runaway_out_n_in(out_n), .chip_reset_n_in(crst_n),
		.out_low_len_out(out_len), .rst_low_len_out(rst_len));

	task automatic results();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// The write response edge is recorded; the register effect lands one edge before it.
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		bready <= 1'b0;
		wr_resp = bresp;
		wr_cyc = cyc;
		if (n >= 100) failures++;
	endtask

	task automatic axi_rd(input logic [4:0] a);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready && arvalid) begin
				arvalid <= 1'b0;
				rd_cyc = cyc;
			end
		end while (rvalid !== 1'b1 && n < 100);
		rready <= 1'b0;
		rd_val = rdata;
		rd_resp = rresp;
		if (n >= 100) failures++;
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input string what);
		axi_rd(a);
		check(what, rd_val, exp);
	endtask

	initial begin
		#300000;
		failures++;
		results();
	end

	initial begin
		int t0;
		int n;
		logic [31:0] c0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		check("out_n idle", out_n, 1);
		check("chip reset idle", crst_n, 1);
		rdc(`RUNAWAY_ADDR_MODE, 32'h0000_0080, "mode reset");
		rdc(`RUNAWAY_ADDR_STATUS, 32'h0000_0000, "status reset");
		rdc(`RUNAWAY_ADDR_MASK, 32'h0000_0003, "mask reset");
		rdc(`RUNAWAY_ADDR_CMD, 32'h0000_0000, "command read");
		axi_rd(5'h14);
		check("unmapped rresp", rd_resp, `RUNAWAY_RESP_SLVERR);
		axi_wr(5'h14, 32'h0000_00FF);
		check("unmapped bresp", wr_resp, `RUNAWAY_RESP_SLVERR);
		axi_rd(`RUNAWAY_ADDR_COUNT);
		check("count started", rd_val[21:0] > 0, 1);
		c0 = rd_val;
		t0 = rd_cyc;
		repeat (50) @(posedge clk);
		axi_rd(`RUNAWAY_ADDR_COUNT);
		n = 2 * int'(rd_val[21:0] - c0[21:0]) - (rd_cyc - t0);
		check("count rate", n >= -2 && n <= 2, 1);
		// Walking down leaves the shortest period selected for the timed overflow.
		for (int p = 3; p >= 0; p--) begin
			axi_wr(`RUNAWAY_ADDR_MODE, 32'h0000_0080 | (p << `RUNAWAY_MODE_PERIOD_LSB));
			rdc(`RUNAWAY_ADDR_MODE, 32'h0000_0080 | (p << `RUNAWAY_MODE_PERIOD_LSB), "period field");
		end
		@(posedge clk);
		standby <= 1'b1;
		repeat (5) @(posedge clk);
		rdc(`RUNAWAY_ADDR_COUNT, 32'h8000_0000, "count in standby");
		standby <= 1'b0;
		busrel_n <= 1'b0;
		repeat (20) @(posedge clk);
		axi_rd(`RUNAWAY_ADDR_COUNT);
		check("bus release flag", rd_val[31], 0);
		check("count in bus release", rd_val[21:0] >= 8, 1);
		busrel_n <= 1'b1;
		axi_wr(`RUNAWAY_ADDR_CMD, `RUNAWAY_CODE_CLEAR);
		axi_rd(`RUNAWAY_ADDR_COUNT);
		check("count cleared", rd_val[21:0] <= 4, 1);
		repeat (200) @(posedge clk);
		axi_wr(`RUNAWAY_ADDR_CMD, 32'h0000_0012);
		axi_wr(`RUNAWAY_ADDR_CMD, `RUNAWAY_CODE_DISABLE);
		axi_rd(`RUNAWAY_ADDR_COUNT);
		check("count kept", rd_val[21:0] >= 100, 1);
		axi_wr(`RUNAWAY_ADDR_CMD, `RUNAWAY_CODE_CLEAR);
		t0 = wr_cyc - 1;
		n = 0;
		while (out_n !== 1'b0 && n < 2 * OVF_CLKS) begin
			@(posedge clk);
			n++;
		end
		check("overflow time", cyc - t0 >= OVF_CLKS - 4 && cyc - t0 <= OVF_CLKS + 4, 1);
		repeat (3) @(posedge clk);
		check("irq on overflow", irq, 1);
		rdc(`RUNAWAY_ADDR_STATUS, 32'h0000_0001, "status overflow");
		axi_wr(`RUNAWAY_ADDR_CMD, `RUNAWAY_CODE_CLEAR);
		check("held after clear", out_n, 0);
		axi_wr(`RUNAWAY_ADDR_MODE, 32'h0000_0000);
		axi_wr(`RUNAWAY_ADDR_CMD, `RUNAWAY_CODE_CLEAR);
		check("held without code", out_n, 0);
		axi_wr(`RUNAWAY_ADDR_CMD, `RUNAWAY_CODE_DISABLE);
		check("held after disable", out_n, 0);
		axi_wr(`RUNAWAY_ADDR_CMD, `RUNAWAY_CODE_CLEAR);
		repeat (2) @(posedge clk);
		check("released", out_n, 1);
		axi_wr(`RUNAWAY_ADDR_STATUS, 32'h0000_0001);
		rdc(`RUNAWAY_ADDR_STATUS, 32'h0000_0000, "status cleared");
		check("irq cleared", irq, 0);
		axi_rd(`RUNAWAY_ADDR_COUNT);
		c0 = rd_val;
		repeat (100) @(posedge clk);
		axi_rd(`RUNAWAY_ADDR_COUNT);
		check("count while disabled", rd_val[21:0] - c0[21:0] >= 45, 1);
		axi_wr(`RUNAWAY_ADDR_CMD, `RUNAWAY_CODE_CLEAR);
		axi_wr(`RUNAWAY_ADDR_MASK, 32'h0000_0002);
		axi_wr(`RUNAWAY_ADDR_MODE, 32'h0000_0084);
		n = 0;
		while (crst_n !== 1'b0 && n < 2 * OVF_CLKS) begin
			@(posedge clk);
			n++;
		end
		check("reset pulse seen", crst_n, 0);
		repeat (40) @(posedge clk);
		check("out pulse length", out_len, `RUNAWAY_RST_PULSE_CYCLES);
		check("reset pulse length", rst_len, `RUNAWAY_RST_PULSE_CYCLES);
		check("out after pulse", out_n, 1);
		check("irq by pulse event", irq, 1);
		rdc(`RUNAWAY_ADDR_STATUS, 32'h0000_0003, "status link");
		axi_wr(`RUNAWAY_ADDR_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		check("irq masked", irq, 0);
		axi_wr(`RUNAWAY_ADDR_STATUS, 32'h0000_0003);
		rdc(`RUNAWAY_ADDR_STATUS, 32'h0000_0000, "status all cleared");
		results();
	end
endmodule
